/* hw/stw_pkg.sv */
package stw_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [3:0] OFS_TMR_CFG = 4'h0;
   localparam logic [3:0] OFS_CMP_A = 4'h1;
   localparam logic [3:0] OFS_CMP_B = 4'h2;
   localparam logic [3:0] OFS_COUNT = 4'h3;
   localparam logic [3:0] OFS_CAL_DIV = 4'h4;
   localparam logic [3:0] OFS_INT_FLAG = 4'h5;
   localparam logic [3:0] OFS_WAKE_EN = 4'h6;
   localparam logic [3:0] OFS_GPIO_WAKE = 4'h7;
   localparam logic [3:0] OFS_PWR_CMD = 4'h8;
   localparam logic [3:0] OFS_WAKE_SRC = 4'h9;
   localparam logic [3:0] OFS_PWR_STAT = 4'ha;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int TMR_SEL_BIT = 4;
   localparam int TMR_EN_BIT = 5;
   localparam int WS_TIMER = 0;
   localparam int WS_IRQ = 1;
   localparam int WS_DEBUG = 2;
   localparam int WS_SERIAL = 3;
   localparam int WS_GPIO = 4;
   localparam int WS_W = 5;
   localparam logic [1:0] CMD_IDLE = 2'h1;
   localparam logic [1:0] CMD_DEEP = 2'h2;
   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [15:0] CAL_DIV_RST = 16'h2710;
   localparam logic [3:0] MAX_DIV = 4'ha;
   localparam logic [3:0] SAVE_CYCLES = 4'h8;
   localparam logic [15:0] CFG_RST = 16'h0000;
   localparam logic [4:0] WAKE_EN_RST = 5'h07;
   typedef enum {PM_ACTIVE, PM_IDLE, PM_SAVE, PM_DEEP, PM_RESTORE} stw_mode_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } stw_bus_t;
endpackage

/* hw/stw_sleep_ctrl.sv */
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module stw_sleep_ctrl #(
   parameter int GPIO_W = 16
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic clk_en_i,
   // Register port
   input wire stw_pkg::stw_bus_t bus_i,
   output logic [15:0] rdata_o,
   // Clock sources, pins (asynchronous)
   input wire logic rc10k_i,
   input wire logic xtal32k_i,
   input wire logic ext_irq_i,
   input wire logic serial_act_i,
   input wire logic serial_debug_port_wake_i,
   input wire logic [GPIO_W-1:0] gpio_in_i,
   // Core side
   input wire logic core_irq_i,
   input wire logic [GPIO_W-1:0] gpio_out_i,
   output logic [GPIO_W-1:0] gpio_out_o,
   output logic cpu_halt_o,
   output logic core_pwr_en_o,
   output logic regulator_output_o,
   output logic lv_rst_b_o,
   output logic ctx_save_o,
   output logic ctx_restore_o,
   output logic serial_rx_en_o,
   output logic irq_cmp_a_o,
   output logic irq_cmp_b_o
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   localparam int SYN_W = 5 + GPIO_W;
   logic [SYN_W-1:0] syn1_r, syn2_r;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         syn1_r <= '0;
         syn2_r <= '0;
      end else if (clk_en_i) begin
         syn1_r <= {gpio_in_i, serial_debug_port_wake_i, serial_act_i, ext_irq_i, xtal32k_i, rc10k_i};
         syn2_r <= syn1_r;
      end
   end
   wire rc_s = syn2_r[0];
   wire xt_s = syn2_r[1];
   wire irq_s = syn2_r[2];
   wire ser_s = syn2_r[3];
   wire dbg_s = syn2_r[4];
   wire [GPIO_W-1:0] gpio_s = syn2_r[SYN_W-1:5];
   logic rc_d_r, xt_d_r;
   logic [GPIO_W-1:0] gpio_d_r;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rc_d_r <= 1'b0;
         xt_d_r <= 1'b0;
         gpio_d_r <= '0;
      end else if (clk_en_i) begin
         rc_d_r <= rc_s;
         xt_d_r <= xt_s;
         gpio_d_r <= gpio_s;
      end
   end
   wire rc_tick = rc_s & ~rc_d_r;
   wire xt_tick = xt_s & ~xt_d_r;
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [15:0] cfg_r, cmp_a_r, cmp_b_r, cal_div_r, gpio_wake_mask_low_r;
   logic [4:0] wake_en_r, wake_src_r;
   logic [15:0] count_r, cal_cnt_r;
   logic [9:0] pre_r;
   logic [1:0] flag_r;
   logic cal_tick_r;
   wire sel_xtal = cfg_r[stw_pkg::TMR_SEL_BIT];
   wire tmr_en = cfg_r[stw_pkg::TMR_EN_BIT];
   wire [3:0] div_n = (cfg_r[3:0] > stw_pkg::MAX_DIV) ? stw_pkg::MAX_DIV : cfg_r[3:0];
   wire base_tick = sel_xtal ? xt_tick : cal_tick_r;
   wire [10:0] pre_next = {1'b0, pre_r} + 11'h001;
   wire pre_done = base_tick & (pre_next == (11'h001 << div_n));
   wire wr_cfg = bus_i.wr & (bus_i.addr == stw_pkg::OFS_TMR_CFG);
   wire wr_a = bus_i.wr & (bus_i.addr == stw_pkg::OFS_CMP_A);
   wire wr_b = bus_i.wr & (bus_i.addr == stw_pkg::OFS_CMP_B);
   wire wr_cnt = bus_i.wr & (bus_i.addr == stw_pkg::OFS_COUNT);
   wire wr_cal = bus_i.wr & (bus_i.addr == stw_pkg::OFS_CAL_DIV);
   wire wr_flag = bus_i.wr & (bus_i.addr == stw_pkg::OFS_INT_FLAG);
   wire wr_wen = bus_i.wr & (bus_i.addr == stw_pkg::OFS_WAKE_EN);
   wire wr_gw = bus_i.wr & (bus_i.addr == stw_pkg::OFS_GPIO_WAKE);
   wire wr_cmd = bus_i.wr & (bus_i.addr == stw_pkg::OFS_PWR_CMD);
   wire wr_src = bus_i.wr & (bus_i.addr == stw_pkg::OFS_WAKE_SRC);
   // Match is taken on the tick that loads the compare value, so a count sitting on it flags once
   wire [15:0] count_nxt = count_r + 16'h0001;
   wire match_a = tmr_en & pre_done & (count_nxt == cmp_a_r);
   wire match_b = tmr_en & pre_done & (count_nxt == cmp_b_r);
   // ----------------------------------------
   // Calibrated source
   // ----------------------------------------
   // A zero divider is stored as one, so the subtraction never underflows
   function automatic logic cal_wrap(input logic [15:0] cnt, input logic [15:0] div);
      cal_wrap = (cnt >= div - 16'h0001);
   endfunction
   wire cal_last = cal_wrap(cal_cnt_r, cal_div_r);
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cal_cnt_r <= '0;
         cal_tick_r <= 1'b0;
      end else if (clk_en_i) begin
         cal_tick_r <= rc_tick & cal_last;
         if (rc_tick) begin
            cal_cnt_r <= cal_last ? 16'h0000 : cal_cnt_r + 16'h0001;
         end
      end
   end
   // Sleep timer and its settings stay in the always-on domain
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count_r <= '0;
         pre_r <= '0;
      end else if (clk_en_i) begin
         if (wr_cnt) begin
            count_r <= bus_i.wdata;
            pre_r <= '0;
         end else if (tmr_en & base_tick) begin
            pre_r <= pre_done ? 10'h000 : pre_next[9:0];
            if (pre_done) begin
               count_r <= count_nxt;
            end
         end
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flag_r <= '0;
      end else if (clk_en_i) begin
         // Set wins over a clear in the same cycle
         flag_r[0] <= match_a | (flag_r[0] & ~(wr_flag & bus_i.wdata[0]));
         flag_r[1] <= match_b | (flag_r[1] & ~(wr_flag & bus_i.wdata[1]));
      end
   end
   assign irq_cmp_a_o = flag_r[0];
   assign irq_cmp_b_o = flag_r[1];
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_r <= stw_pkg::CFG_RST;
         cmp_a_r <= '0;
         cmp_b_r <= '0;
         cal_div_r <= stw_pkg::CAL_DIV_RST;
         wake_en_r <= stw_pkg::WAKE_EN_RST;
         gpio_wake_mask_low_r <= '0;
      end else if (clk_en_i) begin
         if (wr_cfg) cfg_r <= bus_i.wdata;
         if (wr_a) cmp_a_r <= bus_i.wdata;
         if (wr_b) cmp_b_r <= bus_i.wdata;
         if (wr_cal) cal_div_r <= (bus_i.wdata == 16'h0000) ? 16'h0001 : bus_i.wdata;
         if (wr_wen) wake_en_r <= bus_i.wdata[stw_pkg::WS_W-1:0];
         if (wr_gw) gpio_wake_mask_low_r <= bus_i.wdata;
      end
   end
   // ----------------------------------------
   // Power mode sequencer
   // ----------------------------------------
   stw_pkg::stw_mode_t mode_r, mode_nxt;
   logic [3:0] seq_r;
   logic [GPIO_W-1:0] gpio_hold_r;
   wire [GPIO_W-1:0] gpio_chg = (gpio_s ^ gpio_d_r) & gpio_wake_mask_low_r[GPIO_W-1:0];
   wire [stw_pkg::WS_W-1:0] ev_raw = {|gpio_chg, ser_s, dbg_s, irq_s, match_a};
   wire [stw_pkg::WS_W-1:0] ev = ev_raw & wake_en_r;
   wire in_sleep = (mode_r == stw_pkg::PM_SAVE) | (mode_r == stw_pkg::PM_DEEP) | (mode_r == stw_pkg::PM_RESTORE);
   wire seq_done = (seq_r == stw_pkg::SAVE_CYCLES - 4'h1);
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         stw_pkg::PM_ACTIVE: begin
            if (wr_cmd & (bus_i.wdata[1:0] == stw_pkg::CMD_IDLE)) mode_nxt = stw_pkg::PM_IDLE;
            else if (wr_cmd & (bus_i.wdata[1:0] == stw_pkg::CMD_DEEP)) mode_nxt = stw_pkg::PM_SAVE;
         end
         stw_pkg::PM_IDLE: begin
            if (core_irq_i | flag_r[0] | flag_r[1] | irq_s | dbg_s) mode_nxt = stw_pkg::PM_ACTIVE;
         end
         stw_pkg::PM_SAVE: begin
            if (seq_done) mode_nxt = stw_pkg::PM_DEEP;
         end
         stw_pkg::PM_DEEP: begin
            if (|ev) mode_nxt = stw_pkg::PM_RESTORE;
         end
         stw_pkg::PM_RESTORE: begin
            if (seq_done) mode_nxt = stw_pkg::PM_ACTIVE;
         end
         default: mode_nxt = stw_pkg::PM_ACTIVE;
      endcase
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mode_r <= stw_pkg::PM_ACTIVE;
         seq_r <= '0;
      end else if (clk_en_i) begin
         mode_r <= mode_nxt;
         seq_r <= (mode_nxt != mode_r) ? 4'h0 : seq_r + 4'h1;
      end
   end
   // Cause plus any later event until restore ends; set beats software clear
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wake_src_r <= '0;
      end else if (clk_en_i) begin
         wake_src_r <= (wake_src_r & ~({stw_pkg::WS_W{wr_src}} & bus_i.wdata[stw_pkg::WS_W-1:0]))
            | (((mode_r == stw_pkg::PM_DEEP) | (mode_r == stw_pkg::PM_RESTORE)) ? ev : 5'h00);
      end
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gpio_hold_r <= '0;
      end else if (clk_en_i) begin
         if (!in_sleep) gpio_hold_r <= gpio_out_i;
      end
   end
   // Pins see the live value while awake and the latched one from save through restore; pads stay powered
   assign gpio_out_o = in_sleep ? gpio_hold_r : gpio_out_i;
   assign cpu_halt_o = (mode_r != stw_pkg::PM_ACTIVE);
   assign core_pwr_en_o = (mode_r != stw_pkg::PM_DEEP);
   assign regulator_output_o = (mode_r != stw_pkg::PM_DEEP);
   assign lv_rst_b_o = (mode_r != stw_pkg::PM_DEEP);
   assign ctx_save_o = (mode_r == stw_pkg::PM_SAVE);
   assign ctx_restore_o = (mode_r == stw_pkg::PM_RESTORE);
   assign serial_rx_en_o = !in_sleep;
   // ----------------------------------------
   // Read port
   // ----------------------------------------
   wire [2:0] mode_code = (mode_r == stw_pkg::PM_ACTIVE) ? 3'h0 : (mode_r == stw_pkg::PM_IDLE) ? 3'h1 :
      (mode_r == stw_pkg::PM_SAVE) ? 3'h2 : (mode_r == stw_pkg::PM_DEEP) ? 3'h3 : 3'h4;
   logic [15:0] rsel;
   always_comb begin
      if (bus_i.addr == stw_pkg::OFS_TMR_CFG) rsel = cfg_r;
      else if (bus_i.addr == stw_pkg::OFS_CMP_A) rsel = cmp_a_r;
      else if (bus_i.addr == stw_pkg::OFS_CMP_B) rsel = cmp_b_r;
      else if (bus_i.addr == stw_pkg::OFS_COUNT) rsel = count_r;
      else if (bus_i.addr == stw_pkg::OFS_CAL_DIV) rsel = cal_div_r;
      else if (bus_i.addr == stw_pkg::OFS_INT_FLAG) rsel = {14'h0000, flag_r};
      else if (bus_i.addr == stw_pkg::OFS_WAKE_EN) rsel = {11'h000, wake_en_r};
      else if (bus_i.addr == stw_pkg::OFS_GPIO_WAKE) rsel = gpio_wake_mask_low_r;
      else if (bus_i.addr == stw_pkg::OFS_WAKE_SRC) rsel = {11'h000, wake_src_r};
      else if (bus_i.addr == stw_pkg::OFS_PWR_STAT) rsel = {13'h0000, mode_code};
      else rsel = 16'h0000;
   end
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= '0;
      end else if (clk_en_i) begin
         rdata_o <= bus_i.rd ? rsel : 16'h0000;
      end
   end
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence save_run_s;
      mode_r == stw_pkg::PM_SAVE [*8];
   endsequence
   deep_after_save_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      clk_en_i throughout ($rose(mode_r == stw_pkg::PM_SAVE) ##0 save_run_s) |=> mode_r == stw_pkg::PM_DEEP)
      else $error("save phase length wrong");
   cmp_b_nowake_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (mode_r == stw_pkg::PM_DEEP) && clk_en_i && ev == 5'h00 |=> mode_r == stw_pkg::PM_DEEP)
      else $error("deep sleep left without a wake event");
   wake_exit_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (mode_r == stw_pkg::PM_DEEP) && clk_en_i && |ev |=> mode_r == stw_pkg::PM_RESTORE ##0 wake_src_r != 5'h00)
      else $error("wake event not taken");
   reg_off_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      regulator_output_o == (mode_r != stw_pkg::PM_DEEP) && lv_rst_b_o == regulator_output_o)
      else $error("regulator state wrong");
   gpio_freeze_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      clk_en_i && !in_sleep ##1 in_sleep |-> gpio_out_o == $past(gpio_out_i))
      else $error("gpio not frozen at entry value");
   rx_block_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mode_r == stw_pkg::PM_RESTORE |-> !serial_rx_en_o)
      else $error("serial reception on during wake");
   flag_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      clk_en_i && match_a && !wr_cnt && !wr_a |=> irq_cmp_a_o && count_r == cmp_a_r)
      else $error("compare a flag missed");
   wrap_cnt_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      clk_en_i && !wr_cnt && pre_done && tmr_en && count_r == 16'hffff |=> count_r == 16'h0000)
      else $error("counter did not wrap");
   idle_wake_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mode_r == stw_pkg::PM_IDLE && clk_en_i && core_irq_i |=> mode_r == stw_pkg::PM_ACTIVE)
      else $error("idle not left on interrupt");
   // ----------------------------------------
   // Sequencer steps and other checks
   // ----------------------------------------
   sequence restore_run_s;
      mode_r == stw_pkg::PM_RESTORE [*8];
   endsequence
   sequence idle_cmd_s;
      mode_r == stw_pkg::PM_ACTIVE && clk_en_i && wr_cmd && bus_i.wdata[1:0] == stw_pkg::CMD_IDLE;
   endsequence
   sequence deep_cmd_s;
      mode_r == stw_pkg::PM_ACTIVE && clk_en_i && wr_cmd && bus_i.wdata[1:0] == stw_pkg::CMD_DEEP;
   endsequence
   active_after_restore_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      clk_en_i throughout ($rose(mode_r == stw_pkg::PM_RESTORE) ##0 restore_run_s)
      |=> mode_r == stw_pkg::PM_ACTIVE)
      else $error("restore phase length wrong");
   idle_entry_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      idle_cmd_s
      |=> mode_r == stw_pkg::PM_IDLE && cpu_halt_o)
      else $error("idle command not taken");
   save_entry_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      deep_cmd_s
      |=> mode_r == stw_pkg::PM_SAVE && ctx_save_o)
      else $error("deep command not taken");
   idle_stay_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mode_r == stw_pkg::PM_IDLE && clk_en_i && !core_irq_i && flag_r == 2'b00 && !irq_s && !dbg_s
      |=> mode_r == stw_pkg::PM_IDLE)
      else $error("idle left without a cause");
   flag_b_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      clk_en_i && match_b
      |=> irq_cmp_b_o)
      else $error("compare b flag missed");
   b_no_wake_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mode_r == stw_pkg::PM_DEEP && clk_en_i && match_b && !match_a && ev == 5'h00
      |=> mode_r == stw_pkg::PM_DEEP && irq_cmp_b_o)
      else $error("compare b woke the chip");
   deep_freeze_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      in_sleep ##1 in_sleep
      |-> $stable(gpio_out_o))
      else $error("gpio moved while asleep");
   deep_power_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mode_r == stw_pkg::PM_DEEP
      |-> !core_pwr_en_o && gpio_out_o == gpio_hold_r)
      else $error("core powered or pads loose in deep sleep");
   rx_sleep_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      in_sleep
      |-> !serial_rx_en_o)
      else $error("serial reception on while asleep");
   wake_record_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mode_r == stw_pkg::PM_RESTORE && clk_en_i && |ev
      |=> (wake_src_r & $past(ev)) == $past(ev))
      else $error("event during wake not recorded");
   count_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      clk_en_i && !wr_cnt && !pre_done
      |=> $stable(count_r))
      else $error("counter moved between ticks");
endmodule

/* verification/stw_core_model.sv */
`timescale 1ns/100ps
module stw_core_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Bench controls
   input wire logic irq_req_i,
   input wire logic [15:0] gpio_val_i,
   // Block side
   input wire logic core_pwr_en_i,
   input wire logic cpu_halt_i,
   input wire logic serial_rx_en_i,
   input wire logic serial_act_i,
   output logic core_irq_o,
   output logic [15:0] gpio_out_o
);
   logic [15:0] scramble_r;
   logic [3:0] bit_cnt_r;
   // Unpowered core drives nothing valid, so show a value that moves every cycle
   assign gpio_out_o = core_pwr_en_i ? gpio_val_i : scramble_r;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scramble_r <= 16'h0000;
         core_irq_o <= 1'b0;
         bit_cnt_r <= 4'h0;
      end else begin
         scramble_r <= ~gpio_val_i ^ {scramble_r[14:0], ~scramble_r[15]};
         core_irq_o <= irq_req_i & cpu_halt_i;
         // Partial byte seen before reception returns is dropped
         if (!serial_rx_en_i) bit_cnt_r <= 4'h0;
         else if (serial_act_i) bit_cnt_r <= bit_cnt_r + 4'h1;
      end
   end
endmodule

/* verification/stw_sleep_ctrl_bench.sv */
`timescale 1ns/100ps
module stw_sleep_ctrl_bench;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic rc = 1'b0;
   logic xt = 1'b0;
   logic ext_irq = 1'b0;
   logic ser_act = 1'b0;
   logic dbg = 1'b0;
   logic irq_req = 1'b0;
   logic [15:0] gin = 16'h0000;
   logic [15:0] gval = 16'h0000;
   stw_pkg::stw_bus_t bus = '0;
   logic [15:0] rdata, gcore, gout, frz, v, a;
   logic cirq, halt, pwr, reg_on, lv_b, save, rest, rx_en, fa, fb;
   logic [7:0] obs;
   int miscompares = 0;
   int n_tests = 0;
   int seed = 32'hbb37;
   assign obs = {rx_en, rest, save, reg_on, pwr, fb, fa, halt};
   always #4 clk_i = ~clk_i;
   // Source clocks run far faster than real to keep the run short
   always begin
      repeat (4) @(posedge clk_i);
      xt <= ~xt;
   end
   always begin
      repeat (5) @(posedge clk_i);
      rc <= ~rc;
   end
   stw_sleep_ctrl stw_sleep_ctrl_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1), .bus_i(bus),
      .rdata_o(rdata), .rc10k_i(rc), .xtal32k_i(xt), .ext_irq_i(ext_irq), .serial_act_i(ser_act),
      .serial_debug_port_wake_i(dbg), .gpio_in_i(gin), .core_irq_i(cirq), .gpio_out_i(gcore),
      .gpio_out_o(gout), .cpu_halt_o(halt), .core_pwr_en_o(pwr), .regulator_output_o(reg_on),
      .lv_rst_b_o(lv_b), .ctx_save_o(save), .ctx_restore_o(rest), .serial_rx_en_o(rx_en),
      .irq_cmp_a_o(fa), .irq_cmp_b_o(fb));
   stw_core_model stw_core_model_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .irq_req_i(irq_req),
      .gpio_val_i(gval), .core_pwr_en_i(pwr), .cpu_halt_i(halt), .serial_rx_en_i(rx_en),
      .serial_act_i(ser_act), .core_irq_o(cirq), .gpio_out_o(gcore));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic summarize();
      $display("comparisons %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         miscompares++;
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [15:0] d);
      @(posedge clk_i);
      bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] ad, output logic [15:0] d);
      @(posedge clk_i);
      bus <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wait_bit(input int b, input logic lvl, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(posedge clk_i);
         #1 if (obs[b] === lvl) return;
      end
      chk("wait_bit", 16'(b), 16'hffff);
      summarize();
   endtask
   task automatic wait_stat(input logic [15:0] m);
      for (int i = 0; i < 300; i++) begin
         rd(stw_pkg::OFS_PWR_STAT, v);
         if (v === m) return;
      end
      chk("wait_stat", m, v);
      summarize();
   endtask
   task automatic rdchk(input string n, input logic [3:0] ad, input logic [15:0] e);
      rd(ad, v);
      chk(n, e, v);
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rdchk("cfg", stw_pkg::OFS_TMR_CFG, stw_pkg::CFG_RST);
      rdchk("cal_div", stw_pkg::OFS_CAL_DIV, stw_pkg::CAL_DIV_RST);
      rdchk("wake_en", stw_pkg::OFS_WAKE_EN, {11'h000, stw_pkg::WAKE_EN_RST});
      rdchk("unmapped", 4'hf, 16'h0000);
      chk("awake_outs", 16'h001f, {11'h000, rx_en, reg_on, pwr, lv_b, ~halt});
      // Compare channels, random compare value
      a = $random(seed);
      wr(stw_pkg::OFS_CMP_A, a);
      wr(stw_pkg::OFS_CMP_B, a - 16'h0002);
      wr(stw_pkg::OFS_COUNT, a - 16'h0005);
      wr(stw_pkg::OFS_TMR_CFG, 16'h0030);
      wait_bit(1, 1'b1, 2000);
      chk("flag_b_first", 16'h0001, {15'h0000, fb});
      rdchk("flags", stw_pkg::OFS_INT_FLAG, 16'h0003);
      wr(stw_pkg::OFS_INT_FLAG, 16'h0003);
      wr(stw_pkg::OFS_CMP_A, 16'h0001);
      wr(stw_pkg::OFS_COUNT, 16'hfffd);
      wait_bit(1, 1'b1, 2000);
      rd(stw_pkg::OFS_COUNT, v);
      chk("wrapped", 16'h0001, {15'h0000, v < 16'h0010});
      // Prescale values above ten act as ten: one count per 1024 source edges
      wr(stw_pkg::OFS_TMR_CFG, 16'h003b);
      wr(stw_pkg::OFS_COUNT, 16'h0000);
      repeat (9000) @(posedge clk_i);
      rdchk("presc_11", stw_pkg::OFS_COUNT, 16'h0001);
      // Calibrated source: default divider is far too slow to tick here
      wr(stw_pkg::OFS_TMR_CFG, 16'h0020);
      wr(stw_pkg::OFS_COUNT, 16'h0000);
      repeat (400) @(posedge clk_i);
      rdchk("cal_slow", stw_pkg::OFS_COUNT, 16'h0000);
      wr(stw_pkg::OFS_CAL_DIV, 16'h0002);
      wr(stw_pkg::OFS_COUNT, 16'h0000);
      repeat (400) @(posedge clk_i);
      rd(stw_pkg::OFS_COUNT, v);
      chk("cal_fast", 16'h0001, {15'h0000, v >= 16'd17 && v <= 16'd21});
      wr(stw_pkg::OFS_TMR_CFG, 16'h0000);
      wr(stw_pkg::OFS_INT_FLAG, 16'h0003);
      // Idle, left by a core interrupt and then by the debug port
      for (int k = 0; k < 2; k++) begin
         wr(stw_pkg::OFS_PWR_CMD, {14'h0000, stw_pkg::CMD_IDLE});
         wait_stat(16'h0001);
         chk("idle_outs", 16'h0007, {13'h0000, halt, pwr, reg_on});
         if (k == 0) irq_req <= 1'b1;
         else dbg <= 1'b1;
         wait_bit(0, 1'b0, 100);
         irq_req <= 1'b0;
         dbg <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
      // Deep sleep, one wake source at a time
      wr(stw_pkg::OFS_GPIO_WAKE, 16'h0004);
      for (int s = 0; s < 5; s++) begin
         gval <= $random(seed);
         wr(stw_pkg::OFS_WAKE_EN, 16'h0001 << s);
         if (s == 0) begin
            wr(stw_pkg::OFS_COUNT, 16'h0000);
            wr(stw_pkg::OFS_CMP_B, 16'h0006);
            wr(stw_pkg::OFS_CMP_A, 16'h000c);
            wr(stw_pkg::OFS_TMR_CFG, 16'h0030);
         end
         frz = gval;
         wr(stw_pkg::OFS_PWR_CMD, {14'h0000, stw_pkg::CMD_DEEP});
         #1 chk("save", 16'h0001, {15'h0000, save});
         wait_stat(16'h0003);
         chk("deep_outs", 16'h0000, {11'h000, rx_en, reg_on, pwr, lv_b, ~halt});
         chk("lv_reset", 16'h0000, {15'h0000, lv_b});
         repeat (5) @(posedge clk_i);
         chk("frozen", frz, gout);
         if (s == 0) begin
            wait_bit(2, 1'b1, 2000);
            rdchk("b_no_wake", stw_pkg::OFS_PWR_STAT, 16'h0003);
         end
         if (s == 1) ext_irq <= 1'b1;
         if (s == 2) dbg <= 1'b1;
         if (s == 3) ser_act <= 1'b1;
         if (s == 4) begin
            gin <= 16'h0001;
            repeat (30) @(posedge clk_i);
            rdchk("masked_pin", stw_pkg::OFS_PWR_STAT, 16'h0003);
            gin <= 16'h0005;
         end
         wait_bit(6, 1'b1, 2000);
         chk("rx_off_restore", 16'h0000, {15'h0000, rx_en});
         wait_stat(16'h0000);
         chk("woke_outs", 16'h001f, {11'h000, rx_en, reg_on, pwr, lv_b, ~halt});
         rdchk("wake_src", stw_pkg::OFS_WAKE_SRC, 16'h0001 << s);
         {ext_irq, dbg, ser_act} <= 3'b000;
         wr(stw_pkg::OFS_TMR_CFG, 16'h0000);
         wr(stw_pkg::OFS_WAKE_SRC, 16'h001f);
         wr(stw_pkg::OFS_INT_FLAG, 16'h0003);
         rdchk("src_clear", stw_pkg::OFS_WAKE_SRC, 16'h0000);
      end
      summarize();
   end
endmodule
